// [logic/ext_bus_regs.svh]
// Purpose: Bit positions and codes for the byte-enable and bus-hold block.
// Assumes: Configuration bytes are eight bits wide.
// Notes: Definitions only.
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ****************************************************************
// Configuration bit positions
// ****************************************************************
`define HOLD_EN_BIT      7
`define P5_SHARED_BE_BIT 5
`define P5_SHARED_RQ_BIT 4
`define CFG0_BE_SEL_BIT  2

// ****************************************************************
// Byte lane codes and reset values
// ****************************************************************
`define LANE_NONE   2'h0
`define LANE_LOW    2'h1
`define LANE_HIGH   2'h2
`define LANE_WORD   2'h3
`define PIN_IDLE    1'h1
`define OE_OFF_N    1'h1
`define OE_ON_N     1'h0
`define ADDR0_RESET 1'h0
`define CFG_RESET   3'h0

`endif

// [logic/ext_bus_pkg.sv]
// Purpose: Types shared by the byte-enable and bus-hold block.
// Assumes: Nothing beyond the register header.
// Notes: The lane field uses the codes of the register header.
package ext_bus_pkg;

	typedef struct packed {
		logic       active;
		logic       is16;
		logic       write;
		logic       strobe;
		logic [1:0] lanes;
	} bus_cycle_s;

	typedef struct packed {
		logic mode;
		logic dir;
		logic value;
	} pin_cfg_s;

	typedef enum logic [1:0] {
		HOLD_IDLE,
		HOLD_GRANTED,
		HOLD_REQUESTING
	} hold_state_e;

endpackage

// [logic/ext_bus_byte_enable_hold.sv]
// Purpose: Byte-enable and write-high selection on a shared pin, and the bus request
//          output used while another master holds the bus.
// Assumes: Bus cycle information comes from the bus controller on clk; the hold
//          request pin is asynchronous.
// Notes: Pin output enables are active low; a direction bit of one makes a port pin an input.
`timescale 1ns/1ns
`include "ext_bus_regs.svh"

// Summary of operation
// RL1 - Byte high enable and address bit 0 encode word, high byte or low byte.
// RL2 - Shared pin is a bus signal only when its mode bit is set.
// RL3 - Configuration bit selects byte high enable when set, write high strobe when clear.
// RL4 - During hold, bus request goes low while an external cycle is pending.
// RL5 - With hold protocol enabled the request pin is only the bus request output.
// RL6 - Request pin configuration writes are ignored until hold protocol is disabled.
// RL7 - Bus request never asserts before hold acknowledge; one cycle later at the earliest.
// RL8 - Bus request stays asserted until the external master releases hold request.
// RL9 - In 16-bit cycles byte high enable asserts for word and high-byte accesses.
// RL10 - External master keeps hold request asserted while it owns the bus.
module ext_bus_byte_enable_hold
	import ext_bus_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire bus_cycle_s bus_cycle,
	input  wire logic       pending_ext_cycle,
	input  wire logic [7:0] port5_function_select,
	input  wire logic [7:0] port5_direction,
	input  wire logic [7:0] port5_output_value,
	input  wire logic [7:0] chip_config_0,
	input  wire logic [7:0] window_select_reg,
	input  wire logic       hold_req_n,
	output logic            hold_ack_n,
	output logic            bus_request_out_n,
	output logic            high_byte_enable_n,
	output logic            write_high_strobe_n,
	output logic            addr0_out,
	output logic            pin_be_out,
	output logic            pin_be_oe_n,
	output logic            pin_rq_out,
	output logic            pin_rq_oe_n
);

	// ****************************************************************
	// Hold request synchroniser
	// ****************************************************************
	logic        hold_meta_n;
	logic        hold_sync_n;
	logic        hold_req;
	logic        hold_en;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_meta_n <= `PIN_IDLE;
			hold_sync_n <= `PIN_IDLE;
		end else begin
			hold_meta_n <= hold_req_n;
			hold_sync_n <= hold_meta_n;
		end
	end

	assign hold_req = !hold_sync_n;
	assign hold_en  = window_select_reg[`HOLD_EN_BIT];

	// ****************************************************************
	// Hold and bus request sequencing
	// ****************************************************************
	hold_state_e state;
	hold_state_e next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			HOLD_IDLE: begin
				if (hold_en && hold_req && !bus_cycle.active) begin
					next_state = HOLD_GRANTED;
				end
			end
			HOLD_GRANTED: begin
				if (!hold_req) begin
					next_state = HOLD_IDLE;
				// RL4 pending cycle request
				end else if (pending_ext_cycle) begin
					next_state = HOLD_REQUESTING;
				end
			end
			HOLD_REQUESTING: begin
				// RL8 request held until release
				if (!hold_req) begin
					next_state = HOLD_IDLE;
				end
			end
			default: next_state = HOLD_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= HOLD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// RL7 request only inside granted hold
	assign hold_ack_n        = (state == HOLD_IDLE);
	assign bus_request_out_n = (state != HOLD_REQUESTING);

	// ****************************************************************
	// Byte lane and strobe decode
	// ****************************************************************
	function automatic logic lane_has_high(input logic [1:0] lanes);
		return (lanes == `LANE_WORD) || (lanes == `LANE_HIGH);
	endfunction

	logic next_be_n;
	logic next_wr_high_n;
	logic next_a0;

	always_comb begin
		// RL1 lane encoding
		// RL9 high enable in 16-bit cycles
		next_be_n      = !(bus_cycle.active && bus_cycle.is16 && lane_has_high(bus_cycle.lanes));
		next_a0        = bus_cycle.active && (bus_cycle.lanes == `LANE_HIGH);
		next_wr_high_n = !(bus_cycle.active && bus_cycle.is16 && bus_cycle.write &&
			bus_cycle.strobe && lane_has_high(bus_cycle.lanes));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			high_byte_enable_n  <= `PIN_IDLE;
			write_high_strobe_n <= `PIN_IDLE;
			addr0_out           <= `ADDR0_RESET;
		end else begin
			high_byte_enable_n  <= next_be_n;
			write_high_strobe_n <= next_wr_high_n;
			addr0_out           <= next_a0;
		end
	end

	// ****************************************************************
	// Shared pin multiplexing
	// ****************************************************************
	pin_cfg_s rq_cfg;
	pin_cfg_s next_rq_cfg;
	logic     next_be_out;
	logic     next_be_oe_n;
	logic     next_rq_out;
	logic     next_rq_oe_n;
	logic     next_req_n;

	always_comb begin
		next_req_n = (next_state != HOLD_REQUESTING);
		// RL6 freeze request pin setup
		next_rq_cfg = rq_cfg;
		if (!hold_en) begin
			next_rq_cfg.mode  = port5_function_select[`P5_SHARED_RQ_BIT];
			next_rq_cfg.dir   = port5_direction[`P5_SHARED_RQ_BIT];
			next_rq_cfg.value = port5_output_value[`P5_SHARED_RQ_BIT];
		end
		// RL5 hold protocol owns the pin
		if (hold_en || rq_cfg.mode) begin
			next_rq_out  = next_req_n;
			next_rq_oe_n = `OE_ON_N;
		end else begin
			next_rq_out  = rq_cfg.value;
			next_rq_oe_n = rq_cfg.dir;
		end
		// RL2 special function only by mode
		if (port5_function_select[`P5_SHARED_BE_BIT]) begin
			// RL3 enable or write strobe
			next_be_out  = chip_config_0[`CFG0_BE_SEL_BIT] ? next_be_n : next_wr_high_n;
			next_be_oe_n = `OE_ON_N;
		end else begin
			next_be_out  = port5_output_value[`P5_SHARED_BE_BIT];
			next_be_oe_n = port5_direction[`P5_SHARED_BE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rq_cfg      <= `CFG_RESET;
			pin_be_out  <= `PIN_IDLE;
			pin_be_oe_n <= `OE_OFF_N;
			pin_rq_out  <= `PIN_IDLE;
			pin_rq_oe_n <= `OE_OFF_N;
		end else begin
			rq_cfg      <= next_rq_cfg;
			pin_be_out  <= next_be_out;
			pin_be_oe_n <= next_be_oe_n;
			pin_rq_out  <= next_rq_out;
			pin_rq_oe_n <= next_rq_oe_n;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_req_after_ack;
		@(posedge clk) disable iff (!rst_n)
		!bus_request_out_n |-> !hold_ack_n;
	endproperty
	a_req_after_ack: assert property (p_req_after_ack) // RL7
		else $error("bus request asserted without hold acknowledge");

	property p_req_held;
		@(posedge clk) disable iff (!rst_n)
		(!bus_request_out_n && hold_req) |=> !bus_request_out_n;
	endproperty
	a_req_held: assert property (p_req_held) // RL8
		else $error("bus request dropped while hold still requested");

	property p_req_release;
		@(posedge clk) disable iff (!rst_n)
		(!hold_ack_n && !hold_req) |=> (bus_request_out_n && hold_ack_n);
	endproperty
	a_req_release: assert property (p_req_release) // RL8
		else $error("hold not released after request removed");

	property p_req_pending;
		@(posedge clk) disable iff (!rst_n)
		(state == HOLD_GRANTED && hold_req && pending_ext_cycle) |=> !bus_request_out_n;
	endproperty
	a_req_pending: assert property (p_req_pending) // RL4
		else $error("pending cycle did not raise bus request");

	property p_pin_is_req;
		@(posedge clk) disable iff (!rst_n)
		hold_en |=> (!pin_rq_oe_n && pin_rq_out == bus_request_out_n);
	endproperty
	a_pin_is_req: assert property (p_pin_is_req) // RL5
		else $error("request pin not driven as bus request");

	property p_cfg_frozen;
		@(posedge clk) disable iff (!rst_n)
		hold_en |=> $stable(rq_cfg);
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) // RL6
		else $error("request pin setup changed while hold enabled");

	property p_word_lanes;
		@(posedge clk) disable iff (!rst_n)
		(bus_cycle.active && bus_cycle.is16 && bus_cycle.lanes == `LANE_WORD)
			|=> (!high_byte_enable_n && !addr0_out);
	endproperty
	a_word_lanes: assert property (p_word_lanes) // RL9
		else $error("word access lane encoding wrong");

	property p_byte_lanes;
		@(posedge clk) disable iff (!rst_n)
		(bus_cycle.active && bus_cycle.is16 && bus_cycle.lanes == `LANE_LOW)
			|=> (high_byte_enable_n && !addr0_out);
	endproperty
	a_byte_lanes: assert property (p_byte_lanes) // RL1
		else $error("low byte access lane encoding wrong");

	property p_be_gpio;
		@(posedge clk) disable iff (!rst_n)
		!port5_function_select[`P5_SHARED_BE_BIT]
			|=> (pin_be_out == $past(port5_output_value[`P5_SHARED_BE_BIT]));
	endproperty
	a_be_gpio: assert property (p_be_gpio) // RL2
		else $error("shared pin not acting as port pin");

	property p_be_select;
		@(posedge clk) disable iff (!rst_n)
		(port5_function_select[`P5_SHARED_BE_BIT] && chip_config_0[`CFG0_BE_SEL_BIT])
			|=> (pin_be_out == high_byte_enable_n && !pin_be_oe_n);
	endproperty
	a_be_select: assert property (p_be_select) // RL3
		else $error("shared pin not carrying byte high enable");

	c_hold_request: cover property (@(posedge clk) disable iff (!rst_n)
		(state == HOLD_GRANTED) ##1 !bus_request_out_n ##[1:20] bus_request_out_n);
	c_hold_no_req: cover property (@(posedge clk) disable iff (!rst_n)
		(state == HOLD_GRANTED) ##1 hold_ack_n);
	c_write_high_strobe: cover property (@(posedge clk) disable iff (!rst_n)
		!write_high_strobe_n && !chip_config_0[`CFG0_BE_SEL_BIT]);

endmodule // ext_bus_byte_enable_hold

// [sim/hold_master_model.sv]
// Purpose: Model of the outside master that borrows the bus through the hold request.
// Assumes: A start pulse of one cycle begins each ownership period.
// Notes: The request is driven high again when ownership ends.
`timescale 1ns/1ns

module hold_master_model
	import ext_bus_pkg::*;
#(
	parameter int OWN_CYCLES = 10
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      hold_req_n
);
	logic [7:0] remain;
	logic [7:0] next_remain;

	// ****************************************
	// Ownership counter
	// ****************************************
	always_comb begin
		next_remain = remain;
		if (start) begin
			next_remain = 8'(OWN_CYCLES);
		end else if (remain != 8'h00) begin
			next_remain = remain - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		remain <= rst_n ? next_remain : 8'h00;
	end

	assign hold_req_n = (remain == 8'h00);
endmodule // hold_master_model

// [sim/ext_bus_byte_enable_hold_bench.sv]
// Purpose: Self-checking bench for lane decode, shared pin selection and bus hold.
// Assumes: Inputs change on the rising edge; outputs are read on the falling edge.
// Notes: The hold master model supplies the hold request.
`timescale 1ns/1ns

module ext_bus_byte_enable_hold_bench;
	import ext_bus_pkg::*;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	bus_cycle_s  cyc = 6'h00;
	logic        pend = 1'h0;
	logic [7:0]  mode = 8'h00;
	logic [7:0]  dir = 8'h00;
	logic [7:0]  val = 8'h00;
	logic [7:0]  cfg = 8'h00;
	logic [7:0]  win_sel = 8'h00;
	logic        start = 1'h0;
	logic        hreq_n;
	logic        ack_n;
	logic        req_n;
	logic        be_n;
	logic        wr_high_n;
	logic        a0;
	logic        be_pin;
	logic        be_oe_n;
	logic        rq_pin;
	logic        rq_oe_n;
	logic [12:0] rows [7];
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	hold_master_model #(.OWN_CYCLES(10)) partner (.clk(clk), .rst_n(rst_n), .start(start),
		.hold_req_n(hreq_n));

	ext_bus_byte_enable_hold dut (.clk(clk), .rst_n(rst_n), .bus_cycle(cyc),
		.pending_ext_cycle(pend), .port5_function_select(mode), .port5_direction(dir),
		.port5_output_value(val), .chip_config_0(cfg), .window_select_reg(win_sel),
		.hold_req_n(hreq_n), .hold_ack_n(ack_n), .bus_request_out_n(req_n),
		.high_byte_enable_n(be_n), .write_high_strobe_n(wr_high_n), .addr0_out(a0),
		.pin_be_out(be_pin), .pin_be_oe_n(be_oe_n), .pin_rq_out(rq_pin),
		.pin_rq_oe_n(rq_oe_n));

	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 200) begin
			mismatches++;
			end_of_test;
		end
	end

	initial begin
		// Bus cycle, config bit 2, mode bit 5, then be_n a0 wr_high_n pin oe_n.
		rows[0] = {6'h33, 2'h3, 5'h04};
		rows[1] = {6'h32, 2'h3, 5'h0c};
		rows[2] = {6'h31, 2'h3, 5'h16};
		rows[3] = {6'h3f, 2'h1, 5'h00};
		rows[4] = {6'h3d, 2'h1, 5'h16};
		rows[5] = {6'h21, 2'h3, 5'h16};
		rows[6] = {6'h33, 2'h2, 5'h07};
		tick(1);
		check({be_n, wr_high_n, ack_n, req_n, a0}, 5'h1e);
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		dir <= 8'h20;
		val <= 8'h20;
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			cyc <= rows[i][12:7];
			cfg <= {5'h00, rows[i][6], 2'h0};
			mode <= {2'h0, rows[i][5], 5'h00};
			tick(1);
			check({be_n, a0, wr_high_n, be_pin, be_oe_n}, rows[i][4:0]);
		end
		@(posedge clk);
		cyc <= 6'h00;
		win_sel <= 8'h80;
		pend <= 1'h1;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		tick(2);
		check({4'h0, ack_n}, 5'h01);
		tick(1);
		check({2'h0, ack_n, req_n, rq_pin}, 5'h03);
		tick(1);
		check({2'h0, req_n, rq_pin, rq_oe_n}, 5'h00);
		@(posedge clk);
		pend <= 1'h0;
		dir <= 8'h30;
		val <= 8'h30;
		tick(3);
		check({2'h0, req_n, rq_pin, rq_oe_n}, 5'h00);
		tick(4);
		check({3'h0, ack_n, req_n}, 5'h00);
		tick(1);
		check({2'h0, ack_n, req_n, rq_pin}, 5'h07);
		@(posedge clk);
		win_sel <= 8'h00;
		tick(1);
		check({4'h0, rq_oe_n}, 5'h00);
		tick(2);
		check({4'h0, rq_oe_n}, 5'h01);
		@(posedge clk);
		mode <= 8'h10;
		tick(2);
		check({3'h0, rq_pin, rq_oe_n}, 5'h02);
		@(posedge clk);
		win_sel <= 8'h80;
		pend <= 1'h1;
		start <= 1'h1;
		@(posedge clk);
		start <= 1'h0;
		tick(4);
		check({3'h0, ack_n, req_n}, 5'h00);
		@(posedge clk);
		rst_n <= 1'h0;
		tick(1);
		check({1'h0, ack_n, req_n, rq_pin, rq_oe_n}, 5'h0f);
		@(posedge clk);
		rst_n <= 1'h1;
		tick(2);
		check({3'h0, ack_n, req_n}, 5'h03);
		end_of_test;
	end
endmodule // ext_bus_byte_enable_hold_bench
